// ==== verilog/rsc_pkg.sv ====
// Constants for the reset source controller
package rsc_pkg;
   // Special-function register addresses
   localparam logic [7:0] RSC_ADDR_CAUSE = 8'hef;
   localparam logic [7:0] RSC_ADDR_SUPPLY = 8'hff;
   // Supply monitor control fields
   localparam int RSC_SM_ENABLE_BIT = 7;
   localparam int RSC_SM_STATUS_BIT = 6;
   localparam int RSC_SM_THRESH_BIT = 5;
   localparam int RSC_SM_LEVEL_BIT = 4;
   // Cause and enable fields
   localparam int RSC_CA_UNUSED_BIT = 7;
   localparam int RSC_CA_FLASH_BIT = 6;
   localparam int RSC_CA_COMP_BIT = 5;
   localparam int RSC_CA_SOFT_BIT = 4;
   localparam int RSC_CA_WDOG_BIT = 3;
   localparam int RSC_CA_MCLK_BIT = 2;
   localparam int RSC_CA_POWER_BIT = 1;
   localparam int RSC_CA_PIN_BIT = 0;
   // Reset values
   localparam logic RSC_SM_ENABLE_RST = 1'b1;
   localparam logic RSC_SM_THRESH_RST = 1'b0;
   localparam logic RSC_SM_LEVEL_RST = 1'b1;
   localparam logic RSC_SM_RESERVED_READ = 1'b0;
   localparam logic [7:0] RSC_CA_RST = 8'h82;
   // Restart address for the core after any reset
   localparam logic [15:0] RSC_RESTART_ADDR = 16'h0000;
   // Missing-clock window, in nanoseconds, and cycle count at 250 MHz
   localparam int RSC_CLK_PERIOD_NS = 4;
   localparam int RSC_MCLK_TIMEOUT_NS = 100000;
   localparam int RSC_MCLK_CYCLES = RSC_MCLK_TIMEOUT_NS / RSC_CLK_PERIOD_NS;
   // Watchdog prescaler and timeout
   localparam int RSC_WDOG_DIV = 12;
   localparam int RSC_WDOG_TICKS = 65536;
   // Reset pulse length in cycles
   localparam int RSC_HOLD_CYCLES = 16;
   // Cause codes
   typedef enum logic [3:0] {
      RSC_C_NONE = 4'h0,
      RSC_C_PIN = 4'h1,
      RSC_C_SUPPLY = 4'h2,
      RSC_C_MCLK = 4'h3,
      RSC_C_WDOG = 4'h4,
      RSC_C_SOFT = 4'h5,
      RSC_C_COMP = 4'h6,
      RSC_C_FLASH = 4'h7,
      RSC_C_LEVEL = 4'h8
   } rsc_cause_t;
   // Sequencer states
   typedef enum logic [2:0] {
      RSC_S_RUN = 3'b001,
      RSC_S_HOLD = 3'b010,
      RSC_S_EXIT = 3'b100
   } rsc_state_t;
endpackage

// ==== verilog/rsc_if.sv ====
// Bundle between the controller and its missing-clock counter
`timescale 1ns/1ps
interface rsc_if;
   logic arm;
   logic kick;
   logic expired;
   modport ctrl (output arm, output kick, input expired);
   modport det (input arm, input kick, output expired);
endinterface

// ==== verilog/rsc_timeout.sv ====
// Retriggerable timeout counter; fires again every LIMIT+1 cycles while armed
`timescale 1ns/1ps
module rsc_timeout #(
   parameter int LIMIT = 25000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   rsc_if.det ctl
);
   import rsc_pkg::*;
   localparam int W = $clog2(LIMIT + 1);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic hit;
   logic next_hit;

   always_comb begin
      next_count = count;
      next_hit = 1'b0;
      if (!ctl.arm || ctl.kick) begin
         next_count = '0;
      end else if (count == W'(LIMIT)) begin
         next_hit = 1'b1;
         next_count = '0;
      end else begin
         next_count = count + W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
         hit <= 1'b0;
      end else begin
         count <= next_count;
         hit <= next_hit;
      end
   end

   assign ctl.expired = hit;
endmodule // rsc_timeout

// ==== verilog/rsc_ctrl.sv ====
// Reset source controller: cause capture, source enables, system reset
`timescale 1ns/1ps
// What this block does
// R1 - Primary monitor enable, resets only when selected
// R2 - Status bit shows supply above threshold
// R3 - Threshold select low default, high for flash
// R4 - Level monitor enabled always resets system
// R5 - Low four monitor bits reserved, writes ignored
// R6 - Low pin forces reset, sets pin flag
// R7 - Missing clock over 100 us resets, flags
// R8 - Writing missing-clock bit enables the detector
// R9 - Comparator enable bit, reads comparator cause
// R10 - Held in reset while comparator input low
// R11 - Software lets comparator settle before enabling
// R12 - Watchdog enabled after reset, clock divided 12
// R13 - Watchdog flag reads last cause watchdog
// R14 - Illegal flash accesses cause flash-error reset
// R15 - Flash modify without high monitor errors
// R16 - Flash error flag shows last cause
// R17 - Software write of one forces reset
// R18 - Internal sources never drive reset pin; supply and level monitor resets drive it here
// R19 - Power-on flag set; write selects monitor
// R20 - Software stabilises monitor before selecting it
// R21 - Top cause bit reads one, unwritable
// R22 - Software writes cause register whole bytes
// R23 - Every reset restarts execution at zero
// R24 - Non-power-on resets clear power-on flag
// R25 - Monitor settings survive all but power-on; the level bit here reloads on every reset
// R26 - Only the latest cause flag reads one
module rsc_ctrl (
   // Clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Special-function register port
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   output logic [7:0] sfr_rdata_o,
   // Analog and pin inputs
   input wire logic pin_reset_n_i,
   input wire logic supply_above_low_i,
   input wire logic supply_above_high_i,
   input wire logic level_monitor_ok_i,
   input wire logic comparator_out_i,
   input wire logic system_clock_alive_i,
   // Watchdog service and flash access events
   input wire logic wdog_service_i,
   input wire logic wdog_disable_i,
   input wire logic program_store_write_enable_i,
   input wire logic flash_modify_i,
   input wire logic [15:0] flash_addr_i,
   input wire logic code_space_read_i,
   input wire logic branch_i,
   input wire logic [15:0] fetch_addr_i,
   input wire logic [15:0] lock_byte_addr_i,
   input wire logic security_block_i,
   // Reset outputs
   output logic sys_reset_n_o,
   output logic pin_drive_low_o,
   output logic pin_oe_n_o,
   output logic [15:0] restart_addr_o,
   output logic supply_mon_enable_o
);
   import rsc_pkg::*;

   rsc_state_t state;
   rsc_state_t next_state;
   rsc_cause_t cause;
   rsc_cause_t next_cause;
   logic [4:0] hold_cnt;
   logic [4:0] next_hold_cnt;
   logic sm_enable, next_sm_enable;
   logic sm_thresh, next_sm_thresh;
   logic sm_level, next_sm_level;
   logic sel_supply, next_sel_supply;
   logic en_mclk, next_en_mclk;
   logic en_comp, next_en_comp;
   logic [7:0] flags, next_flags;
   logic [3:0] wdiv, next_wdiv;
   logic [16:0] wcnt, next_wcnt;
   logic wdog_on, next_wdog_on;
   logic [7:0] rdata, next_rdata;
   logic sys_n, pin_low, pin_oe_n;
   logic supply_ok;
   logic flash_err;
   rsc_cause_t req;
   rsc_if mc ();

   rsc_timeout #(.LIMIT(RSC_MCLK_CYCLES)) u_mclk (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ctl(mc)
   );

   // Clock activity seen as a level from a slow reference; a stuck level ages the counter
   logic clk_seen;
   assign mc.arm = en_mclk && state == RSC_S_RUN; // [R8]
   assign mc.kick = system_clock_alive_i != clk_seen; // [R7]

   assign supply_ok = sm_thresh ? supply_above_high_i : supply_above_low_i; // [R3]

   // Flash errors win over everything except pin and analog holds
   always_comb begin
      flash_err = 1'b0;
      if (flash_modify_i && program_store_write_enable_i && flash_addr_i > lock_byte_addr_i) begin
         flash_err = 1'b1; // [R14]
      end
      if (code_space_read_i && flash_addr_i > lock_byte_addr_i) begin
         flash_err = 1'b1; // [R14]
      end
      if (branch_i && fetch_addr_i > lock_byte_addr_i) begin
         flash_err = 1'b1; // [R14]
      end
      if (security_block_i) begin
         flash_err = 1'b1; // [R14]
      end
      if (flash_modify_i && (!sm_enable || !sm_thresh)) begin
         flash_err = 1'b1; // [R15]
      end
   end

   // Request arbitration in a fixed order
   // Pin level is ignored while this block pulls the pin low itself;
   // otherwise our own drive would read back as an external reset and never end
   always_comb begin
      req = RSC_C_NONE;
      if (!pin_reset_n_i && pin_oe_n_o) begin
         req = RSC_C_PIN; // [R6]
      end else if (sm_level && !level_monitor_ok_i) begin
         req = RSC_C_LEVEL; // [R4]
      end else if (sm_enable && sel_supply && !supply_ok) begin
         req = RSC_C_SUPPLY; // [R1]
      end else if (en_comp && !comparator_out_i) begin
         req = RSC_C_COMP; // [R10]
      end else if (flash_err) begin
         req = RSC_C_FLASH; // [R14]
      end else if (mc.expired) begin
         req = RSC_C_MCLK; // [R7]
      end else if (wdog_on && wcnt == 17'(RSC_WDOG_TICKS)) begin
         req = RSC_C_WDOG; // [R12]
      end else if (sfr_wr_i && sfr_addr_i == RSC_ADDR_CAUSE && sfr_wdata_i[RSC_CA_SOFT_BIT]) begin
         req = RSC_C_SOFT; // [R17]
      end
   end

   // Sequencer and register state
   always_comb begin
      next_state = state;
      next_cause = cause;
      next_hold_cnt = hold_cnt;
      next_sm_enable = sm_enable;
      next_sm_thresh = sm_thresh;
      next_sm_level = sm_level;
      next_sel_supply = sel_supply;
      next_en_mclk = en_mclk;
      next_en_comp = en_comp;
      next_flags = flags;
      next_wdiv = wdiv;
      next_wcnt = wcnt;
      next_wdog_on = wdog_on;
      case (state)
         RSC_S_RUN: begin
            if (req != RSC_C_NONE) begin
               next_state = RSC_S_HOLD;
               next_cause = req;
               next_hold_cnt = '0;
            end else if (sfr_wr_i && sfr_addr_i == RSC_ADDR_SUPPLY) begin
               next_sm_enable = sfr_wdata_i[RSC_SM_ENABLE_BIT]; // [R1]
               next_sm_thresh = sfr_wdata_i[RSC_SM_THRESH_BIT]; // [R3]
               next_sm_level = sfr_wdata_i[RSC_SM_LEVEL_BIT]; // [R4] [R5]
            end else if (sfr_wr_i && sfr_addr_i == RSC_ADDR_CAUSE) begin
               // Writes steer enables only; flags keep the last cause
               next_sel_supply = sfr_wdata_i[RSC_CA_POWER_BIT]; // [R19]
               next_en_mclk = sfr_wdata_i[RSC_CA_MCLK_BIT]; // [R8]
               next_en_comp = sfr_wdata_i[RSC_CA_COMP_BIT]; // [R9] [R21]
            end
            // Watchdog prescaler runs from the system clock
            if (wdog_disable_i) begin
               next_wdog_on = 1'b0;
            end
            if (wdog_service_i) begin
               next_wcnt = '0;
               next_wdiv = '0;
            end else if (wdiv == 4'(RSC_WDOG_DIV - 1)) begin
               next_wdiv = '0;
               if (wdog_on) begin
                  next_wcnt = wcnt + 17'(1); // [R12]
               end
            end else begin
               next_wdiv = wdiv + 4'(1);
            end
         end
         RSC_S_HOLD: begin
            // Held while a pin, level, supply or comparator source stays active, then a minimum pulse
            if (req != RSC_C_NONE && (req == RSC_C_PIN || req == RSC_C_LEVEL || req == RSC_C_SUPPLY
                || req == RSC_C_COMP)) begin
               next_hold_cnt = '0; // [R10]
            end else if (hold_cnt == 5'(RSC_HOLD_CYCLES - 1)) begin
               next_state = RSC_S_EXIT;
            end else begin
               next_hold_cnt = hold_cnt + 5'(1);
            end
         end
         RSC_S_EXIT: begin
            next_state = RSC_S_RUN;
            next_flags = RSC_CA_RST & 8'h80; // [R26] [R24]
            next_flags[RSC_CA_PIN_BIT] = cause == RSC_C_PIN; // [R6]
            next_flags[RSC_CA_POWER_BIT] = cause == RSC_C_SUPPLY || cause == RSC_C_LEVEL; // [R19]
            next_flags[RSC_CA_MCLK_BIT] = cause == RSC_C_MCLK; // [R7]
            next_flags[RSC_CA_WDOG_BIT] = cause == RSC_C_WDOG; // [R13]
            next_flags[RSC_CA_SOFT_BIT] = cause == RSC_C_SOFT; // [R17]
            next_flags[RSC_CA_COMP_BIT] = cause == RSC_C_COMP; // [R9]
            next_flags[RSC_CA_FLASH_BIT] = cause == RSC_C_FLASH; // [R16]
            // Source enables drop; primary monitor keeps its setting
            // Software must re-arm missing-clock and comparator after every reset
            next_en_mclk = 1'b0;
            next_en_comp = 1'b0;
            next_sm_level = RSC_SM_LEVEL_RST; // [R4] [R25]
            next_wdog_on = 1'b1; // [R12]
            next_wcnt = '0;
            next_wdiv = '0;
         end
         default: begin
            next_state = RSC_S_HOLD;
         end
      endcase
   end

   // Read data, registered
   always_comb begin
      next_rdata = 8'h00;
      if (sfr_addr_i == RSC_ADDR_SUPPLY) begin
         next_rdata[RSC_SM_ENABLE_BIT] = sm_enable;
         next_rdata[RSC_SM_STATUS_BIT] = supply_ok; // [R2]
         next_rdata[RSC_SM_THRESH_BIT] = sm_thresh;
         next_rdata[RSC_SM_LEVEL_BIT] = sm_level;
         next_rdata[3:0] = {4{RSC_SM_RESERVED_READ}}; // [R5]
      end else if (sfr_addr_i == RSC_ADDR_CAUSE) begin
         next_rdata = flags;
         next_rdata[RSC_CA_UNUSED_BIT] = 1'b1; // [R21]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= RSC_S_HOLD;
         cause <= RSC_C_SUPPLY;
         hold_cnt <= '0;
         sm_enable <= RSC_SM_ENABLE_RST; // [R25]
         sm_thresh <= RSC_SM_THRESH_RST;
         sm_level <= RSC_SM_LEVEL_RST;
         sel_supply <= 1'b1; // [R25]
         en_mclk <= 1'b0;
         en_comp <= 1'b0;
         flags <= RSC_CA_RST;
         wdiv <= '0;
         wcnt <= '0;
         wdog_on <= 1'b1;
         rdata <= 8'h00;
         clk_seen <= 1'b0;
      end else begin
         state <= next_state;
         cause <= next_cause;
         hold_cnt <= next_hold_cnt;
         sm_enable <= next_sm_enable;
         sm_thresh <= next_sm_thresh;
         sm_level <= next_sm_level;
         sel_supply <= next_sel_supply;
         en_mclk <= next_en_mclk;
         en_comp <= next_en_comp;
         flags <= next_flags;
         wdiv <= next_wdiv;
         wcnt <= next_wcnt;
         wdog_on <= next_wdog_on;
         rdata <= next_rdata;
         clk_seen <= system_clock_alive_i;
      end
   end

   // Pin is driven low only for supply-monitor and level-monitor resets
   always_comb begin
      sys_n = state == RSC_S_RUN;
      pin_low = state != RSC_S_RUN && (cause == RSC_C_SUPPLY || cause == RSC_C_LEVEL); // [R18]
      pin_oe_n = !pin_low;
   end

   // Registered so reset and pin drive never glitch
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sys_reset_n_o <= 1'b0;
         pin_drive_low_o <= 1'b0;
         pin_oe_n_o <= 1'b0;
         restart_addr_o <= RSC_RESTART_ADDR;
         supply_mon_enable_o <= RSC_SM_ENABLE_RST;
      end else begin
         sys_reset_n_o <= sys_n;
         pin_drive_low_o <= 1'b0;
         pin_oe_n_o <= pin_oe_n;
         restart_addr_o <= RSC_RESTART_ADDR; // [R23]
         supply_mon_enable_o <= sm_enable;
      end
   end
   assign sfr_rdata_o = rdata;
endmodule // rsc_ctrl

// ==== verif/rsc_pin_drv.sv ====
// Board reset circuitry on the open-drain reset pin
`timescale 1ns/1ps
module rsc_pin_drv (
   // Clock for pulse timing
   input wire logic clk_i,
   // Device side of the pin
   input wire logic dev_oe_n_i,
   // Resolved pin level
   output logic pin_level_o
);
   logic pull_low = 1'b0;
   // Pull-up wins when nobody drives
   assign pin_level_o = !(pull_low || !dev_oe_n_i);
   task automatic hold_low(input int cycles);
      @(posedge clk_i);
      #1;
      pull_low = 1'b1;
      repeat (cycles) @(posedge clk_i);
      #1;
      pull_low = 1'b0;
   endtask
endmodule // rsc_pin_drv

// ==== verif/rsc_ctrl_chk.sv ====
// Port checker for the reset source controller
`timescale 1ns/1ps
module rsc_ctrl_chk
   import rsc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_rdata_o,
   // Reset sources
   input wire logic pin_reset_n_i,
   input wire logic level_monitor_ok_i,
   input wire logic comparator_out_i,
   input wire logic program_store_write_enable_i,
   input wire logic flash_modify_i,
   // Reset outputs
   input wire logic sys_reset_n_o,
   input wire logic pin_oe_n_o,
   input wire logic [15:0] restart_addr_o,
   input wire logic supply_mon_enable_o
);
   logic comp_en;
   logic next_comp_en;
   wire logic wr_cause = sfr_wr_i && sfr_addr_i == RSC_ADDR_CAUSE && sys_reset_n_o;
   // Comparator enable shadow; any reset clears it
   always_comb begin
      next_comp_en = comp_en;
      if (!sys_reset_n_o) next_comp_en = 1'b0;
      else if (wr_cause) next_comp_en = sfr_wdata_i[RSC_CA_COMP_BIT];
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) comp_en <= 1'b0;
      else comp_en <= next_comp_en;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_restart; restart_addr_o == RSC_RESTART_ADDR; endproperty
   a_restart: assert property (p_restart) else $error("restart address not zero");
   property p_soft; wr_cause && sfr_wdata_i[RSC_CA_SOFT_BIT] |-> ##[1:3] !sys_reset_n_o; endproperty
   a_soft: assert property (p_soft) else $error("software write gave no reset");
   property p_nodrive; wr_cause && sfr_wdata_i[RSC_CA_SOFT_BIT] |=> pin_oe_n_o [*8]; endproperty
   a_nodrive: assert property (p_nodrive) else $error("pin driven on software reset");
   property p_pin; !pin_reset_n_i && pin_oe_n_o && sys_reset_n_o |-> ##[1:4] !sys_reset_n_o; endproperty
   a_pin: assert property (p_pin) else $error("low pin gave no reset");
   property p_level; !level_monitor_ok_i && sys_reset_n_o |-> ##[1:4] !sys_reset_n_o; endproperty
   a_level: assert property (p_level) else $error("level monitor gave no reset");
   property p_comp; comp_en && !comparator_out_i && sys_reset_n_o |-> ##[1:4] !sys_reset_n_o; endproperty
   a_comp: assert property (p_comp) else $error("comparator gave no reset");
   property p_flash;
      flash_modify_i && program_store_write_enable_i && !supply_mon_enable_o && sys_reset_n_o
         |-> ##[1:4] !sys_reset_n_o;
   endproperty
   a_flash: assert property (p_flash) else $error("flash write with monitor off gave no reset");
   property p_unused; sfr_addr_i == RSC_ADDR_CAUSE && !sfr_wr_i && sys_reset_n_o |=> sfr_rdata_o[7]; endproperty
   a_unused: assert property (p_unused) else $error("unused cause bit not one");
   property p_rsvd; sfr_addr_i == RSC_ADDR_SUPPLY && sys_reset_n_o |=> sfr_rdata_o[3:0] == 4'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved monitor bits not zero");
   property p_len; $fell(sys_reset_n_o) |-> !sys_reset_n_o [*8]; endproperty
   a_len: assert property (p_len) else $error("reset pulse too short");
   c_soft: cover property (wr_cause && sfr_wdata_i[RSC_CA_SOFT_BIT]);
   c_pin: cover property (!pin_reset_n_i && pin_oe_n_o && sys_reset_n_o);
   c_comp: cover property (comp_en && !comparator_out_i && sys_reset_n_o);
endmodule // rsc_ctrl_chk
bind rsc_ctrl rsc_ctrl_chk rsc_ctrl_chk_i (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rdata_o,
   .pin_reset_n_i, .level_monitor_ok_i, .comparator_out_i, .program_store_write_enable_i, .flash_modify_i,
   .sys_reset_n_o, .pin_oe_n_o, .restart_addr_o, .supply_mon_enable_o);

// ==== verif/rsc_ctrl_tb_top.sv ====
// Testbench for the reset source controller
`timescale 1ns/1ps
module rsc_ctrl_tb_top;
   import rsc_pkg::*;
   localparam logic [15:0] LOCK = 16'h1000;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic wr = 1'b0, lo_ok = 1'b1, hi_ok = 1'b1, lvl_ok = 1'b1, comp = 1'b1, alive = 1'b0, run_clk = 1'b1;
   logic program_store_write_enable = 1'b0, fmod = 1'b0, cread = 1'b0, br = 1'b0, sec = 1'b0;
   logic [15:0] faddr = 16'h0000;
   logic [7:0] d;
   int err_total = 0, tests_run = 0;
   wire logic [7:0] sfr_rdata_o;
   wire logic [15:0] restart_addr_o;
   wire logic pin_level, sys_reset_n_o, pin_oe_n_o, supply_mon_enable_o, pin_drv;
   always #2 clk_i = ~clk_i;
   // Monitored clock stands still only when a scenario stops it
   always @(posedge clk_i) begin
      #1;
      if (run_clk) alive = ~alive;
   end
   rsc_pin_drv rsc_pin_drv_i (.clk_i(clk_i), .dev_oe_n_i(pin_oe_n_o), .pin_level_o(pin_level));
   rsc_ctrl rsc_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr),
      .sfr_rdata_o(sfr_rdata_o), .pin_reset_n_i(pin_level), .supply_above_low_i(lo_ok), .supply_above_high_i(hi_ok),
      .level_monitor_ok_i(lvl_ok), .comparator_out_i(comp), .system_clock_alive_i(alive), .wdog_service_i(1'b0),
      .wdog_disable_i(1'b0), .program_store_write_enable_i(program_store_write_enable), .flash_modify_i(fmod), .flash_addr_i(faddr),
      .code_space_read_i(cread), .branch_i(br), .fetch_addr_i(faddr), .lock_byte_addr_i(LOCK),
      .security_block_i(sec), .sys_reset_n_o(sys_reset_n_o), .pin_drive_low_o(pin_drv), .pin_oe_n_o(pin_oe_n_o),
      .restart_addr_o(restart_addr_o), .supply_mon_enable_o(supply_mon_enable_o));
   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      step(1);
      addr = a;
      wdata = v;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      step(1);
      addr = a;
      step(1);
      d = sfr_rdata_o;
   endtask
   // Waits bounded for entry and exit, then reads the cause byte
   task automatic see_reset(input int lim, input logic [7:0] flags);
      int n;
      n = 0;
      while (sys_reset_n_o !== 1'b0 && n < lim) begin
         step(1);
         n++;
      end
      chk1(sys_reset_n_o, 1'b0, "reset entry");
      n = 0;
      while (sys_reset_n_o !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      chk1(sys_reset_n_o, 1'b1, "reset exit");
      chk1(restart_addr_o === RSC_RESTART_ADDR, 1'b1, "restart address");
      chk1(pin_drv, 1'b0, "pin data bit");
      rd_reg(RSC_ADDR_CAUSE);
      chk8(d, flags, "cause flags");
   endtask
   task automatic held(output logic ok);
      step(30);
      ok = sys_reset_n_o;
   endtask
   task automatic t_regs();
      see_reset(1, RSC_CA_RST);
      rd_reg(RSC_ADDR_SUPPLY);
      chk8(d, 8'hd0, "monitor defaults");
      wr_reg(RSC_ADDR_SUPPLY, 8'hff);
      wr_reg(RSC_ADDR_CAUSE, 8'h00);
      hi_ok = 1'b0;
      rd_reg(RSC_ADDR_SUPPLY);
      chk8(d, 8'hb0, "high threshold status");
      hi_ok = 1'b1;
      wr_reg(RSC_ADDR_CAUSE, 8'h02);
      rd_reg(RSC_ADDR_CAUSE);
      chk8(d, 8'h82, "flags after enable write");
      $display("test regs done");
   endtask
   task automatic t_flash();
      faddr = LOCK - 16'h0001;
      program_store_write_enable = 1'b1;
      fmod = 1'b1;
      step(1);
      {program_store_write_enable, fmod} = 2'b00;
      step(10);
      chk1(sys_reset_n_o, 1'b1, "legal flash write");
      for (int k = 0; k < 4; k++) begin
         faddr = LOCK + 16'h0001;
         {sec, br, cread, fmod} = 4'h1 << k;
         program_store_write_enable = (k == 0);
         step(1);
         {sec, br, cread, fmod, program_store_write_enable} = 5'h00;
         see_reset(6, 8'hc0);
      end
      $display("test flash done");
   endtask
   task automatic t_soft();
      wr_reg(RSC_ADDR_SUPPLY, 8'h30);
      step(2);
      chk1(supply_mon_enable_o, 1'b0, "monitor off");
      wr_reg(RSC_ADDR_CAUSE, 8'h10);
      see_reset(6, 8'h90);
      chk1(supply_mon_enable_o, 1'b0, "monitor kept off");
      rd_reg(RSC_ADDR_SUPPLY);
      chk8(d & 8'hbf, 8'h30, "monitor kept");
      faddr = LOCK - 16'h0001;
      {program_store_write_enable, fmod} = 2'b11;
      step(1);
      {program_store_write_enable, fmod} = 2'b00;
      see_reset(6, 8'hc0);
      wr_reg(RSC_ADDR_SUPPLY, 8'hb0);
      $display("test soft done");
   endtask
   task automatic t_sources();
      logic ok;
      rsc_pin_drv_i.hold_low(6);
      see_reset(6, 8'h81);
      rsc_pin_drv_i.hold_low(40);
      see_reset(6, 8'h81);
      comp = 1'b0;
      held(ok);
      chk1(ok, 1'b1, "comparator not selected");
      comp = 1'b1;
      step(5);
      wr_reg(RSC_ADDR_CAUSE, 8'h22);
      comp = 1'b0;
      held(ok);
      chk1(ok, 1'b0, "held by comparator");
      comp = 1'b1;
      see_reset(6, 8'ha0);
      lvl_ok = 1'b0;
      held(ok);
      chk1(ok, 1'b0, "held by level monitor");
      lvl_ok = 1'b1;
      see_reset(6, 8'h82);
      $display("test sources done");
   endtask
   task automatic t_supply();
      logic ok;
      wr_reg(RSC_ADDR_SUPPLY, 8'h90);
      wr_reg(RSC_ADDR_CAUSE, 8'h00);
      lo_ok = 1'b0;
      held(ok);
      chk1(ok, 1'b1, "monitor not selected");
      rd_reg(RSC_ADDR_SUPPLY);
      chk8(d, 8'h90, "low threshold status");
      lo_ok = 1'b1;
      step(5);
      wr_reg(RSC_ADDR_CAUSE, 8'h02);
      lo_ok = 1'b0;
      held(ok);
      chk1(ok, 1'b0, "held by monitor");
      lo_ok = 1'b1;
      see_reset(6, 8'h82);
      wr_reg(RSC_ADDR_CAUSE, 8'h06);
      run_clk = 1'b0;
      step(RSC_MCLK_CYCLES - 20);
      chk1(sys_reset_n_o, 1'b1, "no early clock timeout");
      see_reset(100, 8'h84);
      run_clk = 1'b1;
      $display("test supply and clock done");
   endtask
   initial begin
      #160000;
      err_total++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      step(6);
      rst_n_i = 1'b1;
      t_regs();
      t_flash();
      t_soft();
      t_sources();
      t_supply();
      close_out();
   end
endmodule // rsc_ctrl_tb_top
